// ---- shared/scu_pkg.sv ----
// Constants shared by the smart-card serial interface.
// Assumes a 40 MHz functional clock and a 32-bit Avalon-MM register bus.
package scu_pkg;

  // Clocking: card clock is an integer division of clk
  localparam int CLK_HZ        = 40_000_000;
  localparam int CARD_CLK_HZ   = 5_000_000;
  localparam int CARD_DIV      = CLK_HZ / CARD_CLK_HZ;
  localparam int ETU_CARD_CLKS = 372;
  localparam int ETU_CLKS      = CARD_DIV * ETU_CARD_CLKS;
  localparam int HALF_ETU      = ETU_CLKS / 2;

  localparam int FIFO_DEPTH = 16;

  // Register byte offsets
  localparam logic [5:0] OFF_CTRL     = 6'h00;
  localparam logic [5:0] OFF_GUARD    = 6'h04;
  localparam logic [5:0] OFF_TX_THR   = 6'h08;
  localparam logic [5:0] OFF_TX_DATA  = 6'h0c;
  localparam logic [5:0] OFF_TX_STAT  = 6'h10;
  localparam logic [5:0] OFF_RX_DATA  = 6'h14;
  localparam logic [5:0] OFF_RX_STAT  = 6'h18;
  localparam logic [5:0] OFF_INT_MASK = 6'h1c;
  localparam logic [5:0] OFF_CWT      = 6'h20;

  // Control register fields
  localparam int CTRL_AUTO_NACK_ENABLE = 0;
  localparam int CTRL_CHAR_WAIT_TIMER_ENABLE = 1;
  localparam int CTRL_CRC_CHECK_ENABLE = 2;
  localparam int CTRL_LRC_CHECK_ENABLE = 3;
  localparam int CTRL_XCHK  = 4;
  localparam int CTRL_TXEN  = 5;
  localparam int CTRL_RXEN  = 6;
  localparam int CTRL_RST   = 7;
  localparam int CTRL_PWR   = 8;
  localparam int CTRL_CLKEN = 9;
  localparam int CTRL_W     = 10;
  localparam logic [9:0] CTRL_RESET = 10'h000;

  // Guard time, threshold, mask
  localparam logic [7:0] GUARD_RESET    = 8'h00;
  localparam logic [7:0] GUARD_ONE_STOP = 8'hff;
  localparam logic [3:0] TX_THR_RESET   = 4'h0;
  localparam logic [2:0] MASK_RESET     = 3'h7;

  // Status and interrupt bit positions
  localparam int STAT_TX_THRESHOLD_FLAG = 0;
  localparam int STAT_TC   = 1;
  localparam int INT_RX_DATA_READY_FLAG  = 2;
  localparam int RXE_PE    = 8;
  localparam int RXE_FE    = 9;

  // Check characters
  localparam logic [15:0] CRC_INIT = 16'hffff;
  localparam logic [15:0] CRC_POLY = 16'h1021;

  typedef enum logic [3:0] {
    TX_IDLE = 4'h1,
    TX_BITS = 4'h2,
    TX_STOP = 4'h4,
    TX_NACK = 4'h8
  } scu_tx_state_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'h1,
    RX_BITS = 3'h2,
    RX_WAIT = 3'h4
  } scu_rx_state_t;

endpackage : scu_pkg

// ---- src/scu_top.sv ----
// Smart-card serial interface: card clock, reset, power, single-wire I/O.
// Assumes an Avalon-MM master on clk and an external pull-up on the line.
//
// Function
// - Card clock out; bit time is 372 clocks
// - No phase tie between card clock and data
// - Single shared line, open-drain, external pull-up
// - Parity error stored with byte when NACK off
// - No parity interrupt; NACK pulse when enabled
// - Frame: start, 8 data, parity, 1-2 stops
// - Framing error when stop absent in 11th bit
// - Two stop units plus guard value; one when guard is 0xFF
// - Framing error only with low parity bit
// - Framing error stored, no interrupt, no NACK
// - Wait time counter runs only when enabled
// - Check characters off while answer-to-reset arrives
// - Four-bit transmit threshold level field
// - Transmit FIFO holds up to 16 characters
// - Transmit status flags clear on writing one
// - Set mask bit suppresses its interrupt
// - Check characters appended after block data
// - Transmitter enable starts sending from FIFO
// - Threshold flag when FIFO falls to level
// - Receive-ready flag while characters are waiting
// - Active-low reset output to card
// - Card supply enable output
// - Card presence input sampled
//
// The register offsets and the Avalon-MM interface to the registers are this design's own decisions.
module scu_top
  import scu_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq,
  output logic             card_clock_out,
  output logic             card_reset_out_n,
  output logic             card_power_enable,
  input  wire logic        card_io_in,
  output logic             card_io_out,
  output logic             card_io_oe,
  input  wire logic        card_presence_detect
);

  // Registers
  logic [CTRL_W-1:0] control_reg;
  logic [7:0]        guard_time_control;
  logic [3:0]        tx_threshold_level;
  logic [1:0]        tx_status_reg;
  logic [2:0]        int_mask_reg;
  logic              ack_reg;
  logic [31:0]       rdata_reg;
  logic [2:0]        card_div_reg;
  logic              card_clk_en_reg;
  logic [8:0]        etu_div_reg;
  logic [15:0]       cwt_reg;
  logic [1:0]        io_sync_reg;
  logic [1:0]        pd_sync_reg;
  logic              io_prev_reg;

  // FIFOs
  logic [7:0]  tx_mem [FIFO_DEPTH];
  logic [3:0]  tx_wp_reg;
  logic [3:0]  tx_rp_reg;
  logic [4:0]  tx_cnt_reg;
  logic [9:0]  rx_mem [FIFO_DEPTH];
  logic [3:0]  rx_wp_reg;
  logic [3:0]  rx_rp_reg;
  logic [4:0]  rx_cnt_reg;

  // Transmitter
  scu_tx_state_t tx_state_reg;
  logic [9:0]  tx_shift_reg;
  logic [3:0]  tx_bits_reg;
  logic [8:0]  tx_stops_reg;
  logic [11:0] tx_etu_reg;
  logic [15:0] crc_reg;
  logic [7:0]  lrc_reg;
  logic [1:0]  chk_left_reg;
  logic        block_reg;

  // Receiver
  scu_rx_state_t rx_state_reg;
  logic [11:0] rx_etu_reg;
  logic [3:0]  rx_idx_reg;
  logic [7:0]  rx_data_reg;
  logic        rx_par_reg;

  // Bus decode
  wire bus_req   = avs_read | avs_write;
  wire bus_acc   = bus_req & ack_reg;
  wire wr_acc    = avs_write & ack_reg;
  wire rd_acc    = avs_read & ack_reg;
  wire wr_ctrl   = wr_acc & (avs_address == OFF_CTRL);
  wire wr_guard  = wr_acc & (avs_address == OFF_GUARD);
  wire wr_thr    = wr_acc & (avs_address == OFF_TX_THR);
  wire wr_txd    = wr_acc & (avs_address == OFF_TX_DATA);
  wire wr_tstat  = wr_acc & (avs_address == OFF_TX_STAT);
  wire wr_mask   = wr_acc & (avs_address == OFF_INT_MASK);
  wire rd_rxd    = rd_acc & (avs_address == OFF_RX_DATA);

  // Derived status
  wire io_line      = io_sync_reg[1];
  wire card_present = pd_sync_reg[1];
  wire rx_data_ready_flag = (rx_cnt_reg != 5'd0);
  wire tx_full      = (tx_cnt_reg == 5'(FIFO_DEPTH));
  wire rx_full      = (rx_cnt_reg == 5'(FIFO_DEPTH));
  wire [2:0] int_src = {rx_data_ready_flag, tx_status_reg};

  // Card pins
  assign card_clock_out    = card_clk_en_reg & ~card_div_reg[2];
  assign card_reset_out_n  = control_reg[CTRL_RST];
  assign card_power_enable = control_reg[CTRL_PWR];
  assign card_io_out       = 1'b0;
  assign card_io_oe        = (tx_state_reg == TX_BITS & ~tx_shift_reg[0])
                           | (tx_state_reg == TX_NACK);
  assign irq               = |(int_src & ~int_mask_reg);

  // Register read mux
  wire [31:0] rd_mux =
      (avs_address == OFF_CTRL)     ? {22'h0, control_reg} :
      (avs_address == OFF_GUARD)    ? {24'h0, guard_time_control} :
      (avs_address == OFF_TX_THR)   ? {28'h0, tx_threshold_level} :
      (avs_address == OFF_TX_STAT)  ? {22'h0, tx_cnt_reg, 3'h0,
                                       tx_status_reg} :
      (avs_address == OFF_RX_DATA)  ? {22'h0, rx_mem[rx_rp_reg]} :
      (avs_address == OFF_RX_STAT)  ? {22'h0, rx_cnt_reg, 3'h0,
                                       card_present, rx_data_ready_flag} :
      (avs_address == OFF_INT_MASK) ? {29'h0, int_mask_reg} :
      (avs_address == OFF_CWT)      ? {16'h0, cwt_reg} : 32'h0;

  assign avs_waitrequest = bus_req & ~ack_reg;
  assign avs_readdata    = rdata_reg;

  // Bus handshake: one wait cycle, read data captured ahead of release
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ack_reg   <= 1'b0;
      rdata_reg <= 32'h0;
    end
    else
    begin
      ack_reg <= bus_req & ~ack_reg;
      if (avs_read & ~ack_reg)
        rdata_reg <= rd_mux;
    end
  end

  // Control registers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      control_reg        <= CTRL_RESET;
      guard_time_control <= GUARD_RESET;
      tx_threshold_level <= TX_THR_RESET;
      int_mask_reg       <= MASK_RESET;
    end
    else
    begin
      if (wr_ctrl)
        control_reg <= avs_writedata[CTRL_W-1:0];
      if (wr_guard)
        guard_time_control <= avs_writedata[7:0];
      if (wr_thr)
        tx_threshold_level <= avs_writedata[3:0];
      if (wr_mask)
        int_mask_reg <= avs_writedata[2:0];
    end
  end

  // Pin synchronisers
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      io_sync_reg <= 2'b11;
      pd_sync_reg <= 2'b00;
      io_prev_reg <= 1'b1;
    end
    else
    begin
      io_sync_reg <= {io_sync_reg[0], card_io_in};
      pd_sync_reg <= {pd_sync_reg[0], card_presence_detect};
      io_prev_reg <= io_sync_reg[1];
    end
  end

  // Card clock divider and free-running bit-time tick
  // Enable is taken only at a period boundary, so no short card clock pulse
  wire card_tick = (card_div_reg == 3'(CARD_DIV - 1));
  wire etu_tick  = card_tick & (etu_div_reg == 9'(ETU_CARD_CLKS - 1));
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      card_div_reg    <= 3'h0;
      etu_div_reg     <= 9'h0;
      card_clk_en_reg <= 1'b0;
    end
    else
    begin
      card_div_reg <= card_tick ? 3'h0 : card_div_reg + 3'h1;
      if (card_tick)
        card_clk_en_reg <= control_reg[CTRL_CLKEN];
      if (card_tick)
        etu_div_reg <= etu_tick ? 9'h0 : etu_div_reg + 9'h1;
    end
  end

  // Character wait time counter, restarted by each start bit
  wire rx_start = (rx_state_reg == RX_IDLE) & control_reg[CTRL_RXEN]
                & (tx_state_reg == TX_IDLE) & io_prev_reg & ~io_line;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cwt_reg <= 16'h0;
    else if (!control_reg[CTRL_CHAR_WAIT_TIMER_ENABLE] || rx_start)
      cwt_reg <= 16'h0;
    else if (etu_tick && cwt_reg != 16'hffff)
      cwt_reg <= cwt_reg + 16'h1;
  end

  // CRC update over one byte, most significant bit first
  function automatic logic [15:0] crc_byte(input logic [15:0] c,
                                           input logic [7:0]  d);
    logic [15:0] r;
    r = c;
    for (int i = 7; i >= 0; i--)
      r = {r[14:0], 1'b0} ^ ((r[15] ^ d[i]) ? CRC_POLY : 16'h0);
    return r;
  endfunction : crc_byte

  // Transmit decisions
  wire tx_etu_end  = (tx_etu_reg == 12'(ETU_CLKS - 1));
  wire chk_on      = control_reg[CTRL_XCHK]
                   & (control_reg[CTRL_CRC_CHECK_ENABLE] | control_reg[CTRL_LRC_CHECK_ENABLE]);
  wire tx_load_dat = (tx_state_reg == TX_IDLE) & control_reg[CTRL_TXEN]
                   & (tx_cnt_reg != 5'd0);
  wire tx_load_chk = (tx_state_reg == TX_IDLE) & control_reg[CTRL_TXEN]
                   & (tx_cnt_reg == 5'd0) & block_reg
                   & (chk_left_reg != 2'd0);
  wire tx_done_blk = (tx_state_reg == TX_IDLE) & (tx_cnt_reg == 5'd0)
                   & block_reg & (chk_left_reg == 2'd0);
  wire [7:0] chk_byte = control_reg[CTRL_CRC_CHECK_ENABLE]
                      ? ((chk_left_reg == 2'd2) ? crc_reg[15:8]
                                                : crc_reg[7:0])
                      : lrc_reg;
  wire [7:0] tx_byte = tx_load_dat ? tx_mem[tx_rp_reg] : chk_byte;
  wire [8:0] stop_units = (guard_time_control == GUARD_ONE_STOP)
                        ? 9'd1 : 9'd2 + {1'b0, guard_time_control};
  wire nack_req;
  wire tx_push = wr_txd & ~tx_full;
  wire tx_pop  = tx_load_dat;

  // Transmit FIFO
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_wp_reg  <= 4'h0;
      tx_rp_reg  <= 4'h0;
      tx_cnt_reg <= 5'h0;
    end
    else
    begin
      if (tx_push)
        tx_wp_reg <= tx_wp_reg + 4'h1;
      if (tx_pop)
        tx_rp_reg <= tx_rp_reg + 4'h1;
      tx_cnt_reg <= tx_cnt_reg + 5'(tx_push) - 5'(tx_pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (tx_push)
      tx_mem[tx_wp_reg] <= avs_writedata[7:0];
  end

  // Transmit state machine: 10 driven bits, then stop/guard units
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state_reg <= TX_IDLE;
      tx_shift_reg <= 10'h3ff;
      tx_bits_reg  <= 4'h0;
      tx_stops_reg <= 9'h0;
      tx_etu_reg   <= 12'h0;
      crc_reg      <= CRC_INIT;
      lrc_reg      <= 8'h0;
      chk_left_reg <= 2'd0;
      block_reg    <= 1'b0;
    end
    else
    begin
      tx_etu_reg <= (tx_state_reg == TX_IDLE || tx_etu_end)
                  ? 12'h0 : tx_etu_reg + 12'h1;
      case (tx_state_reg)
        TX_IDLE:
        begin
          if (tx_load_dat || tx_load_chk)
          begin
            tx_shift_reg <= {^tx_byte, tx_byte, 1'b0};
            tx_bits_reg  <= 4'd10;
            tx_state_reg <= TX_BITS;
          end
          else if (nack_req)
            tx_state_reg <= TX_NACK;
          if (tx_load_dat)
          begin
            crc_reg <= crc_byte(crc_reg, tx_byte);
            lrc_reg <= lrc_reg ^ tx_byte;
            if (!block_reg)
              chk_left_reg <= !chk_on ? 2'd0 :
                              control_reg[CTRL_CRC_CHECK_ENABLE] ? 2'd2 : 2'd1;
            block_reg <= 1'b1;
          end
          if (tx_load_chk)
            chk_left_reg <= chk_left_reg - 2'd1;
          if (tx_done_blk)
          begin
            block_reg <= 1'b0;
            crc_reg   <= CRC_INIT;
            lrc_reg   <= 8'h0;
          end
        end
        TX_BITS:
        begin
          if (tx_etu_end)
          begin
            tx_shift_reg <= {1'b1, tx_shift_reg[9:1]};
            tx_bits_reg  <= tx_bits_reg - 4'h1;
            if (tx_bits_reg == 4'd1)
            begin
              tx_stops_reg <= stop_units;
              tx_state_reg <= TX_STOP;
            end
          end
        end
        TX_STOP:
        begin
          if (tx_etu_end)
          begin
            tx_stops_reg <= tx_stops_reg - 9'h1;
            if (tx_stops_reg == 9'd1)
              tx_state_reg <= TX_IDLE;
          end
        end
        TX_NACK:
        begin
          if (tx_etu_end)
            tx_state_reg <= TX_IDLE;
        end
        default:
          tx_state_reg <= TX_IDLE;
      endcase
    end
  end

  // Transmit status: set beats write-one-to-clear
  wire tx_threshold_flag_set = control_reg[CTRL_TXEN] & block_reg
                & (tx_cnt_reg <= {1'b0, tx_threshold_level});
  wire tc_set   = tx_done_blk;
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      tx_status_reg <= 2'b00;
    else
    begin
      tx_status_reg[STAT_TX_THRESHOLD_FLAG] <= tx_threshold_flag_set | (tx_status_reg[STAT_TX_THRESHOLD_FLAG]
                                & ~(wr_tstat & avs_writedata[STAT_TX_THRESHOLD_FLAG]));
      tx_status_reg[STAT_TC]   <= tc_set | (tx_status_reg[STAT_TC]
                                & ~(wr_tstat & avs_writedata[STAT_TC]));
    end
  end

  // Receive sampling at mid bit; index 10 is the 11th bit time
  wire rx_etu_end = (rx_etu_reg == 12'h0);
  wire rx_stop_at = (rx_state_reg == RX_BITS) & rx_etu_end
                  & (rx_idx_reg == 4'd10);
  wire rx_pe      = rx_par_reg ^ (^rx_data_reg);
  wire rx_fe      = ~io_line & ~rx_par_reg;
  wire rx_nack    = rx_pe & control_reg[CTRL_AUTO_NACK_ENABLE];
  wire rx_push    = rx_stop_at & ~rx_nack & ~rx_full;
  wire rx_pop     = rd_rxd & rx_data_ready_flag;
  assign nack_req = rx_stop_at & rx_nack;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_state_reg <= RX_IDLE;
      rx_etu_reg   <= 12'h0;
      rx_idx_reg   <= 4'h0;
      rx_data_reg  <= 8'h0;
      rx_par_reg   <= 1'b0;
    end
    else
    begin
      case (rx_state_reg)
        RX_IDLE:
        begin
          if (rx_start)
          begin
            rx_etu_reg   <= 12'(HALF_ETU);
            rx_idx_reg   <= 4'h0;
            rx_state_reg <= RX_BITS;
          end
        end
        RX_BITS:
        begin
          rx_etu_reg <= rx_etu_end ? 12'(ETU_CLKS - 1)
                                   : rx_etu_reg - 12'h1;
          if (rx_etu_end)
          begin
            rx_idx_reg <= rx_idx_reg + 4'h1;
            if (rx_idx_reg == 4'd0 && io_line)
              rx_state_reg <= RX_IDLE;                          // False start
            else if (rx_idx_reg <= 4'd8 && rx_idx_reg != 4'd0)
              rx_data_reg <= {io_line, rx_data_reg[7:1]};
            else if (rx_idx_reg == 4'd9)
              rx_par_reg <= io_line;
            else if (rx_idx_reg == 4'd10)
              rx_state_reg <= RX_WAIT;
          end
        end
        RX_WAIT:
        begin
          if (io_line && tx_state_reg != TX_NACK)
            rx_state_reg <= RX_IDLE;                            // Late stop
        end
        default:
          rx_state_reg <= RX_IDLE;
      endcase
    end
  end

  // Receive FIFO: byte with parity and framing flags
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_wp_reg  <= 4'h0;
      rx_rp_reg  <= 4'h0;
      rx_cnt_reg <= 5'h0;
    end
    else
    begin
      if (rx_push)
        rx_wp_reg <= rx_wp_reg + 4'h1;
      if (rx_pop)
        rx_rp_reg <= rx_rp_reg + 4'h1;
      rx_cnt_reg <= rx_cnt_reg + 5'(rx_push) - 5'(rx_pop);
    end
  end

  always_ff @(posedge clk)
  begin
    if (rx_push)
      rx_mem[rx_wp_reg] <= {rx_fe, rx_pe, rx_data_reg};
  end

endmodule : scu_top

// ---- testbench/scu_card_model.sv ----
// Behavioural card on the single open-drain I/O line.
// Assumes the bench resolves the line with a pull-up.
module scu_card_model
  import scu_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       line,
  output logic            card_pull,
  output logic [7:0]      rx_byte,
  output logic            rx_par,
  output logic [7:0]      rx_count
);
  timeunit 1ns;
  timeprecision 1ps;

  // Send start, data LSB first, parity, optional late stop, stop
  task automatic send_char(input logic [7:0] d, input logic par,
                           input logic late);
    card_pull <= 1'b1;
    repeat (ETU_CLKS) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      card_pull <= ~d[i];
      repeat (ETU_CLKS) @(posedge clk);
    end
    card_pull <= ~par;
    repeat (ETU_CLKS) @(posedge clk);
    card_pull <= late;
    repeat (ETU_CLKS) @(posedge clk);
    card_pull <= 1'b0;
    repeat (2 * ETU_CLKS) @(posedge clk);
  endtask : send_char

  // Capture what the device sends; our own drive is ignored
  initial
  begin
    card_pull = 1'b0;
    rx_count = 8'h00;
    rx_byte = 8'h00;
    rx_par = 1'b0;
    forever
    begin
      @(posedge clk);
      if (line === 1'b0 && !card_pull)
      begin
        repeat (HALF_ETU) @(posedge clk);
        for (int i = 0; i < 9; i++)
        begin
          repeat (ETU_CLKS) @(posedge clk);
          if (i < 8)
            rx_byte[i] = line;
          else
            rx_par = line;
        end
        rx_count = rx_count + 8'h01;
        wait (line === 1'b1);
      end
    end
  end
endmodule : scu_card_model

// ---- testbench/scu_checker.sv ----
// Port assertions for the smart-card serial interface.
// Assumes it is bound to scu_top and clocked by clk at 40 MHz.
module scu_checker
  import scu_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic [5:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        irq,
  input wire logic        card_clock_out,
  input wire logic        card_reset_out_n,
  input wire logic        card_power_enable,
  input wire logic        card_io_in,
  input wire logic        card_io_out,
  input wire logic        card_io_oe,
  input wire logic        card_presence_detect
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] oe_run_reg;
  wire         taken;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  // A transfer completes where waitrequest is low
  assign taken = (avs_read || avs_write) && !avs_waitrequest;

  // Counts cycles the line has been pulled low in one run
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      oe_run_reg <= 16'h0000;
    else if (card_io_oe)
      oe_run_reg <= oe_run_reg + 16'h0001;
    else
      oe_run_reg <= 16'h0000;
  end

  // Card clock phases
  sequence s_clk_high;
    card_clock_out [*4] ##1 !card_clock_out;
  endsequence
  sequence s_clk_low;
    !card_clock_out [*4] ##1 card_clock_out;
  endsequence

  AST_CLK_HIGH: assert property ($rose(card_clock_out) |-> s_clk_high)
    else $error("card clock high phase wrong");
  AST_CLK_LOW: assert property ($fell(card_clock_out) |-> s_clk_low)
    else $error("card clock low phase wrong");
  AST_OPEN_DRAIN: assert property (card_io_oe |-> !card_io_out)
    else $error("line driven high");
  AST_TX_BIT_TIME: assert property ($fell(card_io_oe) |->
    oe_run_reg != 16'h0000 && oe_run_reg % ETU_CLKS == 0)
    else $error("low run not whole bit times");
  AST_RESET_STATE: assert property ($rose(rst_n) |->
    !card_reset_out_n && !card_power_enable && !card_io_oe && !irq &&
    !card_clock_out)
    else $error("outputs not idle after reset");
  AST_PINS_HOLD: assert property (!taken |=>
    $stable(card_reset_out_n) && $stable(card_power_enable))
    else $error("card pins moved without a write");
  AST_ONE_WAIT: assert property
    ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("waitrequest held too long");
  AST_UNMAPPED_ZERO: assert property
    (avs_read && !avs_waitrequest && avs_address > 6'h20 |->
     avs_readdata == 32'h00000000)
    else $error("unmapped read not zero");
endmodule : scu_checker

bind scu_top scu_checker scu_checker_inst (
  .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write),
  .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .irq(irq),
  .card_clock_out(card_clock_out), .card_reset_out_n(card_reset_out_n),
  .card_power_enable(card_power_enable), .card_io_in(card_io_in),
  .card_io_out(card_io_out), .card_io_oe(card_io_oe),
  .card_presence_detect(card_presence_detect));

// ---- testbench/scu_top_test.sv ----
// Self-checking bench for the smart-card serial interface.
// Assumes the card model and checker are compiled before it.
module scu_top_test
  import scu_pkg::*;
  ();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst_n;
  logic [5:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        irq;
  logic        card_clock_out;
  logic        card_reset_out_n;
  logic        card_power_enable;
  logic        card_io_out;
  logic        card_io_oe;
  logic        card_presence_detect;
  logic        card_pull;
  logic [7:0]  rx_byte;
  logic        rx_par;
  logic [7:0]  rx_count;
  logic [31:0] rd;
  int          n;
  int          n_mismatch = 0;
  int          comparisons = 0;
  wire         card_io_line;

  // Open-drain line with pull-up
  assign card_io_line = (card_io_oe ? card_io_out : 1'b1) & ~card_pull;

  scu_top scu_top_inst (
    .clk(clk), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq),
    .card_clock_out(card_clock_out), .card_reset_out_n(card_reset_out_n),
    .card_power_enable(card_power_enable), .card_io_in(card_io_line),
    .card_io_out(card_io_out), .card_io_oe(card_io_oe),
    .card_presence_detect(card_presence_detect));

  scu_card_model scu_card_model_inst (
    .clk(clk), .line(card_io_line), .card_pull(card_pull),
    .rx_byte(rx_byte), .rx_par(rx_par), .rx_count(rx_count));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Compare and count
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One Avalon-MM transfer, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [31:0] d);
    logic done;
    int   k;
    done = 1'b0;
    k = 0;
    @(posedge clk);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    while (!done && k < 100)
    begin
      @(posedge clk);
      done = (avs_waitrequest === 1'b0);
      if (done)
        rd = avs_readdata;
      k++;
    end
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    if (!done)
      n_mismatch++;
  endtask : bus

  // Read a register and compare the masked value
  task automatic rcheck(input logic [5:0] a, input logic [31:0] m,
                        input logic [31:0] e);
    bus(1'b0, a, 32'h00000000);
    check(rd & m, e);
  endtask : rcheck

  // Report and end the run
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : test_done

  // Main sequence
  initial
  begin
    rst_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h00000000;
    card_presence_detect = 1'b0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rcheck(OFF_CTRL, 32'hffffffff, 32'h00000000);
    rcheck(OFF_INT_MASK, 32'hffffffff, {29'h0, MASK_RESET});
    rcheck(OFF_TX_STAT, 32'hffffffff, 32'h00000000);
    rcheck(OFF_RX_STAT, 32'hffffffff, 32'h00000000);
    rcheck(6'h3c, 32'hffffffff, 32'h00000000);
    bus(1'b1, OFF_TX_THR, 32'h0000001f);
    rcheck(OFF_TX_THR, 32'hffffffff, 32'h0000000f);
    for (int i = 0; i < 17; i++)
      bus(1'b1, OFF_TX_DATA, 32'h00000030 + 32'(i));
    rcheck(OFF_TX_STAT, 32'h000003e0, 32'h00000200);
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    card_presence_detect <= 1'b1;
    rcheck(OFF_TX_STAT, 32'hffffffff, 32'h00000000);
    rcheck(OFF_TX_THR, 32'hffffffff, 32'h00000000);
    bus(1'b1, OFF_CTRL, 32'h000003c0);
    @(negedge clk);
    check({30'h0, card_reset_out_n, card_power_enable}, 32'h3);
    rcheck(OFF_RX_STAT, 32'h00000003, 32'h00000002);
    scu_card_model_inst.send_char(8'h01, 1'b0, 1'b1);
    rcheck(OFF_RX_STAT, 32'h000003e1, 32'h00000021);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, OFF_INT_MASK, 32'h00000003);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    rcheck(OFF_RX_DATA, 32'h000003ff, 32'h00000301);
    rcheck(OFF_RX_STAT, 32'h00000001, 32'h00000000);
    rcheck(OFF_CWT, 32'hffffffff, 32'h00000000);
    bus(1'b1, OFF_TX_DATA, 32'h000000a5);
    bus(1'b1, OFF_CTRL, 32'h000003e0);
    n = 0;
    while (rx_count === 8'h00 && n < 40000)
    begin
      @(posedge clk);
      n++;
    end
    check({23'h0, rx_par, rx_byte}, {23'h0, ^8'ha5, 8'ha5});
    n = 0;
    rd = 32'h00000000;
    while (rd[STAT_TC] !== 1'b1 && n < 4000)
    begin
      bus(1'b0, OFF_TX_STAT, 32'h00000000);
      n++;
    end
    check(rd & 32'h00000003, 32'h00000003);
    check({24'h0, rx_count}, 32'h00000001);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, OFF_INT_MASK, 32'h00000000);
    @(negedge clk);
    check({31'h0, irq}, 32'h1);
    bus(1'b1, OFF_TX_STAT, 32'h00000000);
    rcheck(OFF_TX_STAT, 32'h00000003, 32'h00000003);
    bus(1'b1, OFF_TX_STAT, 32'h00000003);
    rcheck(OFF_TX_STAT, 32'h00000003, 32'h00000000);
    @(negedge clk);
    check({31'h0, irq}, 32'h0);
    bus(1'b1, OFF_CTRL, 32'h000003e2);
    repeat (2 * ETU_CLKS - 1) @(posedge clk);
    rcheck(OFF_CWT, 32'hffffffff, 32'h00000002);
    test_done();
  end

  // Watchdog against a hang
  initial
  begin
    repeat (95000) @(posedge clk);
    n_mismatch++;
    test_done();
  end
endmodule : scu_top_test
